// ==== core/mic_map.svh ====
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH

// ****************************************
// immediate command codes (byte 0)
// ****************************************
`define MIC_CODE_NULL 8'h00
`define MIC_CODE_SET_POS 8'h05
`define MIC_CODE_FORCE_AOUT 8'h06
`define MIC_CODE_POS_INC_UPD 8'h07
`define MIC_CODE_IN_POS_ZONE 8'h08
`define MIC_CODE_MOVE 8'h09
`define MIC_CODE_JOG_VEL 8'h0A
`define MIC_CODE_JOG_ACC 8'h0B
`define MIC_CODE_POS_LOOP_TC 8'h0C
`define MIC_CODE_FEEDFWD 8'h0D
`define MIC_CODE_INTEG_TC 8'h2C
`define MIC_CODE_RATIO 8'h2D
`define MIC_CODE_VEL_GAIN 8'h2E
`define MIC_CODE_SEL_AOUT 8'h47
`define MIC_CODE_LOAD_PARAM 8'h50

// ****************************************
// move type byte fields
// ****************************************
`define MIC_MT_CMOVE_BIT 0
`define MIC_MT_SCURVE_BIT 4
`define MIC_MT_INC_BIT 6
`define MIC_MT_PARAM_BIT 7
`define MIC_MT_RESERVED_MASK 8'h2E

// ****************************************
// analog output, limits, error codes
// ****************************************
`define MIC_AOUT_MODE_FORCED 8'h00
`define MIC_AOUT_FIRST_DIGITAL_CONN 2'h2
`define MIC_MIN_JOG_ACC_COUNTS 32'h00000020
`define MIC_RATIO_MAX_UP 32'h00000020
`define MIC_RATIO_MAX_DOWN 32'h00002710
`define MIC_RATIO_MAX_DOWN_OLD 32'h00000020
`define MIC_ERR_NONE 8'h00
`define MIC_ERR_ENC_REF 8'h53
`define MIC_ERR_PROG_ACTIVE 8'h60
`define MIC_ERR_MOVE_TYPE 8'h61
`define MIC_ERR_RATIO_DEN 8'h62
`define MIC_ERR_RATIO_RANGE 8'h63
`define MIC_ERR_DIGITAL_ONLY 8'h64
`define MIC_ERR_AOUT_CONN 8'h65

`endif

// ==== core/mic_pkg.sv ====
`default_nettype none

package mic_pkg;

	// six-byte command: byte5..byte2 = data, byte1 = arg, byte0 = code
	typedef struct packed {
		logic [31:0] data;
		logic [7:0] arg;
		logic [7:0] code;
	} mic_cmd_t;

	typedef struct packed {
		logic [31:0] in_pos_zone;
		logic [31:0] jog_vel;
		logic [31:0] jog_acc;
		logic [15:0] pos_loop_tc;
		logic [7:0] ff_pct;
		logic [15:0] integ_tc;
		logic [15:0] ratio_a;
		logic [15:0] ratio_b;
		logic [7:0] vel_gain_code;
	} mic_param_t;

	typedef struct packed {
		logic enable;
		logic overridden;
		logic [1:0] connector;
		logic [15:0] millivolts;
	} mic_analog_t;

	typedef struct packed {
		logic valid;
		logic move;
		logic [31:0] amount;
	} mic_pos_upd_t;

	typedef struct packed {
		logic valid;
		logic [31:0] value;
	} mic_set_pos_t;

	typedef struct packed {
		logic start;
		logic absolute;
		logic cmove;
		logic scurve;
		logic [31:0] target;
		logic [31:0] velocity;
		logic [31:0] accel_counts;
	} mic_move_t;

	typedef struct packed {
		mic_param_t params;
		logic [31:0] jog_acc_counts;
		logic in_zone;
		mic_analog_t analog;
		mic_pos_upd_t pos_upd;
		mic_set_pos_t set_pos;
		mic_move_t move;
		logic status_error;
		logic [7:0] error_code;
	} mic_state_t;

endpackage : mic_pkg

`default_nettype wire

// ==== core/mic_decoder.sv ====
`include "mic_map.svh"
`default_nettype none

// How it works
// - battery lost, no reference: ignore, report 53h
// - forced value scales linearly, 32000 is 10 V
// - force must repeat; any command other than force or output select cancels it
// - digital mode output routing overrides, restores force
// - increment updates both positions, moves if enabled
// - zone flag when idle and error within tolerance
// - tolerance reverts to configured on reset
// - each move starts profile at jog values
// - move byte bits pick stop, curve, incremental
// - bit 7 takes target from stored parameter
// - move rejected while a program is active
// - jog velocity, reverts to configured on reset
// - jog acceleration, reverts to configured on reset
// - scaled jog acceleration floored at 32 counts
// - loop time constant, reverts on reset
// - feedforward percent, reverts on reset
// - integrator time constant in milliseconds
// - numerator signed, denominator 1 to 32767
// - ratio magnitude outside limits raises error
// - velocity gain code, digital mode only, reverts
module mic_decoder (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_reset,
	input wire logic cmd_strobe,
	input wire mic_pkg::mic_cmd_t cmd,
	input wire logic digital_mode,
	input wire logic servo_enabled,
	input wire logic moving,
	input wire logic program_active,
	input wire logic [31:0] position_error,
	input wire logic encoder_battery_lost,
	input wire logic encoder_ref_passed,
	input wire logic legacy_ratio_limit,
	input wire logic [15:0] counts_per_unit,
	input wire mic_pkg::mic_param_t cfg,
	output mic_pkg::mic_param_t params,
	output logic [31:0] jog_acc_counts,
	output logic in_zone,
	output mic_pkg::mic_analog_t analog,
	output mic_pkg::mic_pos_upd_t pos_update,
	output mic_pkg::mic_set_pos_t set_position,
	output mic_pkg::mic_move_t move,
	output logic status_error,
	output logic [7:0] error_code
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] abs32(input logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction : abs32

	function automatic logic [15:0] to_millivolts(input logic [15:0] v);
		logic signed [19:0] p;
		p = 20'(signed'(v)) * 20'sh00005;
		return p[19:4];
	endfunction : to_millivolts

	// ****************************************
	// state
	// ****************************************
	mic_pkg::mic_state_t st;
	mic_pkg::mic_state_t next_st;
	// parameter store kept outside the state record: 256 words would bloat it
	logic [31:0] param_mem [0:255];

	logic [47:0] acc_scaled;
	logic [31:0] ratio_num_mag;
	logic [31:0] ratio_den;
	logic [31:0] ratio_down_limit;
	logic [31:0] move_type;

	always_ff @(posedge ref_clk) begin
		if (cmd_strobe && cmd.code == `MIC_CODE_LOAD_PARAM) begin
			param_mem[cmd.arg] <= cmd.data;
		end
	end

	always_comb begin
		next_st = st;
		next_st.pos_upd.valid = 1'b0;
		next_st.set_pos.valid = 1'b0;
		next_st.move.start = 1'b0;
		next_st.status_error = 1'b0;
		acc_scaled = {16'h0000, st.params.jog_acc} * {32'h00000000, counts_per_unit};
		ratio_num_mag = abs32({{16{cmd.data[15]}}, cmd.data[15:0]});
		ratio_den = {16'h0000, cmd.data[31:16]};
		ratio_down_limit = legacy_ratio_limit ? `MIC_RATIO_MAX_DOWN_OLD : `MIC_RATIO_MAX_DOWN;
		move_type = {24'h000000, cmd.arg};

		// floor keeps a slow user unit from stalling profiles
		if (acc_scaled < {16'h0000, `MIC_MIN_JOG_ACC_COUNTS}) begin
			next_st.jog_acc_counts = `MIC_MIN_JOG_ACC_COUNTS;
		end else begin
			next_st.jog_acc_counts = acc_scaled[31:0];
		end

		next_st.in_zone = !moving && (abs32(position_error) <= st.params.in_pos_zone);

		if (cmd_strobe) begin
			// force lasts only while the host repeats it each scan
			if (cmd.code != `MIC_CODE_FORCE_AOUT && cmd.code != `MIC_CODE_SEL_AOUT) begin
				next_st.analog.enable = 1'b0;
				next_st.analog.millivolts = 16'h0000;
			end
			case (cmd.code)
				`MIC_CODE_SET_POS: begin
					if (encoder_battery_lost && !encoder_ref_passed) begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_ENC_REF;
					end else begin
						next_st.set_pos.valid = 1'b1;
						next_st.set_pos.value = cmd.data;
					end
				end
				`MIC_CODE_FORCE_AOUT: begin
					if (digital_mode && cmd.arg[1:0] < `MIC_AOUT_FIRST_DIGITAL_CONN) begin
						next_st.analog.enable = 1'b0;
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_AOUT_CONN;
					end else begin
						next_st.analog.enable = 1'b1;
						next_st.analog.connector = cmd.arg[1:0];
						next_st.analog.millivolts = to_millivolts(cmd.data[15:0]);
					end
				end
				`MIC_CODE_SEL_AOUT: begin
					if (digital_mode) begin
						next_st.analog.overridden = (cmd.data[7:0] != `MIC_AOUT_MODE_FORCED);
					end else begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_DIGITAL_ONLY;
					end
				end
				`MIC_CODE_POS_INC_UPD: begin
					next_st.pos_upd.valid = 1'b1;
					next_st.pos_upd.move = servo_enabled;
					next_st.pos_upd.amount = cmd.data;
				end
				`MIC_CODE_IN_POS_ZONE: begin
					next_st.params.in_pos_zone = cmd.data;
				end
				`MIC_CODE_MOVE: begin
					if ((cmd.arg & `MIC_MT_RESERVED_MASK) != 8'h00) begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_MOVE_TYPE;
					end else if (program_active) begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_PROG_ACTIVE;
					end else begin
						next_st.move.start = 1'b1;
						next_st.move.cmove = move_type[`MIC_MT_CMOVE_BIT];
						next_st.move.scurve = move_type[`MIC_MT_SCURVE_BIT];
						next_st.move.absolute = !move_type[`MIC_MT_INC_BIT];
						if (move_type[`MIC_MT_PARAM_BIT]) begin
							next_st.move.target = param_mem[cmd.data[7:0]];
						end else begin
							next_st.move.target = cmd.data;
						end
						next_st.move.velocity = st.params.jog_vel;
						next_st.move.accel_counts = st.jog_acc_counts;
					end
				end
				`MIC_CODE_JOG_VEL: begin
					next_st.params.jog_vel = cmd.data;
				end
				`MIC_CODE_JOG_ACC: begin
					next_st.params.jog_acc = cmd.data;
				end
				`MIC_CODE_POS_LOOP_TC: begin
					next_st.params.pos_loop_tc = cmd.data[15:0];
				end
				`MIC_CODE_FEEDFWD: begin
					next_st.params.ff_pct = cmd.data[7:0];
				end
				`MIC_CODE_INTEG_TC: begin
					next_st.params.integ_tc = cmd.data[15:0];
				end
				`MIC_CODE_RATIO: begin
					if (ratio_den == 32'h00000000 || ratio_den[15]) begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_RATIO_DEN;
					end else if (ratio_num_mag > ratio_den * `MIC_RATIO_MAX_UP
						|| ratio_num_mag * ratio_down_limit < ratio_den) begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_RATIO_RANGE;
					end else begin
						next_st.params.ratio_a = cmd.data[15:0];
						next_st.params.ratio_b = cmd.data[31:16];
					end
				end
				`MIC_CODE_VEL_GAIN: begin
					if (digital_mode) begin
						next_st.params.vel_gain_code = cmd.data[7:0];
					end else begin
						next_st.status_error = 1'b1;
						next_st.error_code = `MIC_ERR_DIGITAL_ONLY;
					end
				end
				default: begin
				end
			endcase
		end

		// host reset or power-up drops every commanded value except the stored parameter words
		if (rst || host_reset) begin
			next_st = '0;
			next_st.params = cfg;
			next_st.jog_acc_counts = `MIC_MIN_JOG_ACC_COUNTS;
			next_st.error_code = `MIC_ERR_NONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		st <= next_st;
	end

	// ****************************************
	// outputs, all registered
	// ****************************************
	assign params = st.params;
	assign jog_acc_counts = st.jog_acc_counts;
	assign in_zone = st.in_zone;
	assign analog = st.analog;
	assign pos_update = st.pos_upd;
	assign set_position = st.set_pos;
	assign move = st.move;
	assign status_error = st.status_error;
	assign error_code = st.error_code;

endmodule : mic_decoder

`default_nettype wire

// ==== test/mic_host_model.sv ====
`default_nettype none
// ****
// host scan model
// ****
module mic_host_model (
	input wire logic en,
	input wire mic_pkg::mic_cmd_t word,
	output logic cmd_strobe,
	output mic_pkg::mic_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	// the slot is resent every scan, so an idle slot must carry null
	assign cmd_strobe = en;
	assign cmd = en ? word : '0;
endmodule : mic_host_model
`default_nettype wire

// ==== test/mic_checker.sv ====
`default_nettype none
// ****
// port checks
// ****
module mic_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_reset,
	input wire logic cmd_strobe,
	input wire mic_pkg::mic_cmd_t cmd,
	input wire logic digital_mode,
	input wire logic servo_enabled,
	input wire logic moving,
	input wire logic program_active,
	input wire logic [31:0] position_error,
	input wire logic encoder_battery_lost,
	input wire logic encoder_ref_passed,
	input wire mic_pkg::mic_param_t cfg,
	input wire mic_pkg::mic_param_t params,
	input wire logic in_zone,
	input wire mic_pkg::mic_analog_t analog,
	input wire mic_pkg::mic_pos_upd_t pos_update,
	input wire mic_pkg::mic_set_pos_t set_position,
	input wire mic_pkg::mic_move_t move,
	input wire logic status_error,
	input wire logic [7:0] error_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tk;
	logic [7:0] c;
	logic [31:0] ae;
	assign tk = cmd_strobe && !rst && !host_reset;
	assign c = cmd.code;
	assign ae = position_error[31] ? -position_error : position_error;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || host_reset);
	a_set_pos_refused: assert property (
		tk && c == 8'h05 && encoder_battery_lost && !encoder_ref_passed
		|=> !set_position.valid && error_code == 8'h53) else $error("set position not refused");
	a_force_cancel: assert property (
		analog.enable && tk && c != 8'h06 && c != 8'h47 |=> !analog.enable)
		else $error("force not cancelled");
	a_incr_update: assert property (
		tk && c == 8'h07 |=> pos_update.valid && pos_update.amount == $past(cmd.data)
		&& pos_update.move == $past(servo_enabled)) else $error("increment wrong");
	a_zone_flag: assert property (
		!$past(rst) && !$past(host_reset)
		|-> in_zone == $past(!moving && ae <= params.in_pos_zone)) else $error("zone flag wrong");
	a_move_start: assert property (
		tk && c == 8'h09 && !program_active && (cmd.arg & 8'hAE) == 8'h00
		|=> move.start && move.target == $past(cmd.data) && move.absolute == !$past(cmd.arg[6])
		&& move.scurve == $past(cmd.arg[4]) && move.velocity == params.jog_vel)
		else $error("move start wrong");
	a_move_busy: assert property (
		tk && c == 8'h09 && program_active && (cmd.arg & 8'h2E) == 8'h00
		|=> !move.start && status_error && error_code == 8'h60)
		else $error("busy move not refused");
	a_bad_type: assert property (
		tk && c == 8'h09 && (cmd.arg & 8'h2E) != 8'h00 |=> !move.start && error_code == 8'h61)
		else $error("bad move type not refused");
	a_gain_digital: assert property (
		tk && c == 8'h2E && !digital_mode |=> error_code == 8'h64 && $stable(params.vel_gain_code))
		else $error("gain taken outside digital mode");
	a_params_revert: assert property (
		disable iff (1'b0) rst || host_reset |=> params == $past(cfg)) else $error("no revert");
	c_move: cover property (move.start);
	c_force: cover property (analog.enable);
	a_force_override: assert property (
		tk && c == 8'h47 && digital_mode |=> analog.overridden == ($past(cmd.data[7:0]) != 8'h00)
		&& analog.enable == $past(analog.enable)) else $error("analog mode select wrong");
	c_error: cover property (status_error);
	c_override: cover property (analog.enable && analog.overridden);
endmodule : mic_checker

bind mic_decoder mic_checker u_chk (.ref_clk, .rst, .host_reset, .cmd_strobe, .cmd,
	.digital_mode, .servo_enabled, .moving, .program_active, .position_error,
	.encoder_battery_lost, .encoder_ref_passed, .cfg, .params, .in_zone, .analog,
	.pos_update, .set_position, .move, .status_error, .error_code);
`default_nettype wire

// ==== test/mic_decoder_tb.sv ====
`default_nettype none
// ****
// decoder bench
// ****
module mic_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, host_reset = 0, en = 0, cmd_strobe, in_zone, status_error;
	logic digital_mode = 0, servo_enabled = 0, moving = 0, program_active = 0;
	logic encoder_battery_lost = 0, encoder_ref_passed = 0, legacy_ratio_limit = 0;
	logic [31:0] position_error = '0, jog_acc_counts;
	logic [15:0] counts_per_unit = 16'h0002;
	logic [7:0] error_code;
	logic [7:0] mt [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h40, 8'h41, 8'h50, 8'h51};
	mic_pkg::mic_cmd_t word = '0, cmd;
	mic_pkg::mic_param_t params;
	mic_pkg::mic_param_t cfg = {32'h4, 32'h64, 32'h5, 16'h20, 8'h50, 16'h100, 16'h1, 16'h1, 8'h10};
	mic_pkg::mic_analog_t analog;
	mic_pkg::mic_pos_upd_t pos_update;
	mic_pkg::mic_set_pos_t set_position;
	mic_pkg::mic_move_t move;
	int errors = 0, checks_done = 0, cycles = 0;

	mic_host_model host (.en, .word, .cmd_strobe, .cmd);
	mic_decoder dut (.ref_clk, .rst, .host_reset, .cmd_strobe, .cmd, .digital_mode, .servo_enabled,
		.moving, .program_active, .position_error, .encoder_battery_lost, .encoder_ref_passed,
		.legacy_ratio_limit, .counts_per_unit, .cfg, .params, .jog_acc_counts, .in_zone, .analog,
		.pos_update, .set_position, .move, .status_error, .error_code);

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			complete_run();
		end
	end

	task automatic ck(input string n, input logic [175:0] e, input logic [175:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask : ck

	// the word stays in the slot afterwards, so checks come before the next edge
	task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [31:0] d, input int n);
		word = {d, a, c};
		repeat (n) @(negedge ref_clk);
	endtask : op

	task automatic complete_run;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 0;
		en = 1;
		ck("reset", cfg, params);
		ck("floor", 32'h20, jog_acc_counts);
		op(8'h08, 8'h00, 32'hA, 1);
		position_error = -32'sd10;
		@(negedge ref_clk);
		ck("zone in", 1'b1, in_zone);
		position_error = -32'sd11;
		@(negedge ref_clk);
		ck("zone out", 1'b0, in_zone);
		position_error = '0;
		moving = 1;
		@(negedge ref_clk);
		ck("zone moving", 1'b0, in_zone);
		moving = 0;
		op(8'h0B, 8'h00, 32'h64, 2);
		ck("acc", 32'hC8, jog_acc_counts);
		op(8'h0A, 8'h00, 32'h300, 1);
		op(8'h0C, 8'h00, 32'h7, 1);
		op(8'h0D, 8'h00, 32'h5A, 1);
		op(8'h2C, 8'h00, 32'h90, 1);
		ck("tune", {16'h7, 8'h5A, 16'h90}, {params.pos_loop_tc, params.ff_pct, params.integ_tc});
		op(8'h09, 8'h51, 32'h1234, 1);
		ck("move", {32'h1234, 32'h300, 32'hC8}, {move.target, move.velocity, move.accel_counts});
		foreach (mt[i]) begin
			op(8'h09, mt[i], 32'h40, 1);
			ck("type", {1'b1, ~mt[i][6], mt[i][0], mt[i][4]}, {move.start, move.absolute, move.cmove, move.scurve});
		end
		op(8'h50, 8'h07, 32'h5678, 1);
		op(8'h09, 8'hD1, 32'h7, 1);
		ck("param move", 32'h5678, move.target);
		program_active = 1;
		op(8'h09, 8'h00, 32'h40, 1);
		ck("busy", {1'b0, 8'h60}, {move.start, error_code});
		program_active = 0;
		op(8'h09, 8'h02, 32'h40, 1);
		ck("bad type", {2'b01, 8'h61}, {move.start, status_error, error_code});
		encoder_battery_lost = 1;
		op(8'h05, 8'h00, 32'h55, 1);
		ck("set refused", {1'b0, 8'h53}, {set_position.valid, error_code});
		encoder_ref_passed = 1;
		op(8'h05, 8'h00, 32'h56, 1);
		ck("set taken", {1'b1, 32'h56}, set_position);
		servo_enabled = 1;
		op(8'h07, 8'h00, 32'h9, 1);
		ck("increment", {2'b11, 32'h9}, pos_update);
		op(8'h06, 8'h02, 32'h7D00, 2);
		ck("force high", {2'b10, 2'h2, 16'h2710}, analog);
		op(8'h06, 8'h03, 32'hFFFF8300, 1);
		ck("force low", {2'b10, 2'h3, 16'hD8F0}, analog);
		op(8'h00, 8'h00, 32'h0, 1);
		ck("force off", 1'b0, analog.enable);
		op(8'h2D, 8'h00, {16'h1, 16'h21}, 1);
		ck("ratio up", {1'b1, 8'h63}, {status_error, error_code});
		op(8'h2D, 8'h00, {16'h0, 16'h1}, 1);
		ck("ratio zero", 8'h62, error_code);
		op(8'h2D, 8'h00, {16'h2, 16'hFFFF}, 1);
		ck("ratio ok", {1'b0, 16'hFFFF, 16'h2}, {status_error, params.ratio_a, params.ratio_b});
		legacy_ratio_limit = 1;
		op(8'h2D, 8'h00, {16'h21, 16'h1}, 1);
		ck("ratio old", {1'b1, 8'h63}, {status_error, error_code});
		op(8'h2E, 8'h00, 32'h20, 1);
		ck("gain analog", {8'h64, 8'h10}, {error_code, params.vel_gain_code});
		digital_mode = 1;
		op(8'h2E, 8'h00, 32'h20, 1);
		ck("gain", 8'h20, params.vel_gain_code);
		op(8'h06, 8'h02, 32'h7D00, 1);
		op(8'h47, 8'h00, 32'h1, 1);
		ck("override", {2'b11, 2'h2}, {analog.enable, analog.overridden, analog.connector});
		op(8'h47, 8'h00, 32'h0, 1);
		ck("restore", 2'b10, {analog.enable, analog.overridden});
		op(8'h06, 8'h00, 32'h7D00, 1);
		ck("force refused", {1'b0, 8'h65}, {analog.enable, error_code});
		op(8'h00, 8'h00, 32'h0, 1);
		host_reset = 1;
		@(negedge ref_clk);
		host_reset = 0;
		ck("revert", cfg, params);
		complete_run();
	end
endmodule : mic_decoder_tb
`default_nettype wire
